/* pkg/msfc_pkg.sv */
// package for the modem status and hardware flow control block:
// register offsets, field positions, reset values and carrier types.
// assumes a 32-bit classic wishbone bus with byte addresses on wb_adr_in.
package msfc_pkg;
  // register byte offsets, one aligned word each
  localparam logic [7:0] ADR_MODEM_LINE_STATUS = 8'h00;
  localparam logic [7:0] ADR_SCRATCH_STORAGE = 8'h04;
  localparam logic [7:0] ADR_ENHANCED_FEATURE = 8'h08;
  localparam logic [7:0] ADR_IRQ_STATUS = 8'h0C;
  localparam logic [7:0] ADR_IRQ_MASK = 8'h10;
  localparam logic [7:0] ADR_FLOW_CONFIG = 8'h14;
  localparam logic [7:0] ADR_FLOW_CHARS = 8'h18;
  // enhanced feature control field positions
  localparam int EFC_AUTO_CTS = 7;
  localparam int EFC_AUTO_RTS = 6;
  // flow config fields: trigger select [1:0], manual rts [2]
  localparam int FCFG_MANUAL_RTS = 2;
  // irq status / mask bit positions
  localparam int IRQ_MODEM = 0;
  localparam int IRQ_RX_TRIG = 1;
  // reset values
  localparam logic [7:0] EFC_RESET = 8'h00;
  localparam logic [7:0] SCRATCH_RESET = 8'h00;
  localparam logic [2:0] FCFG_RESET = 3'h0;
  localparam logic [1:0] IRQ_MASK_RESET = 2'h0;
  localparam logic [15:0] CHARS_RESET = 16'h0000;
  // receive fifo trigger levels, selected by trigger select
  localparam logic [6:0] TRIG_LVL_0 = 7'h08;
  localparam logic [6:0] TRIG_LVL_1 = 7'h10;
  localparam logic [6:0] TRIG_LVL_2 = 7'h38;
  localparam logic [6:0] TRIG_LVL_3 = 7'h3C;
  // software flow selection for one direction
  typedef enum logic [1:0] {
    MSFC_SW_NONE = 2'h0,
    MSFC_SW_FIRST = 2'h1,
    MSFC_SW_SECOND = 2'h2,
    MSFC_SW_BOTH = 2'h3
  } msfc_sw_mode_t;
  // handshake pins from the modem, all active low
  typedef struct packed {
    logic cd_n;
    logic ri_n;
    logic dsr_n;
    logic cts_n;
  } msfc_pins_t;
endpackage

/* core/msfc_core.sv */
// modem status change detection, scratch storage and hardware flow control
// for one uart channel, reached over a classic wishbone slave.
// assumes modem pins and fifo level are synchronous to clk_sys_in.
//
// Function
// - dsr change sets its flag until read
// - cts change sets flag bit 0
// - any change flag raises modem interrupt
// - eight-bit scratch register, no side effects
// - auto cts halts transmit while cts high
// - auto rts interrupts at programmed trigger level
// - auto rts raises rts at next level
// - rts drops below next lower level
// - without auto rts, rts follows manual setting
// - auto rts bit reads back flow status; here it reads back as written, and flow status reads from flow config bit 8
// - low feature bits choose software flow modes
// - dual characters are matched in order
// - both auto flow enables reset to zero
// - current character finishes before pausing
//
// Chosen here: register access over Wishbone and the address map.
`timescale 1ns/100ps
`default_nettype none
module msfc_core (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  input wire msfc_pkg::msfc_pins_t pins_in,
  input wire logic [6:0] rx_level_in,
  input wire logic tx_busy_in,
  input wire logic rx_char_valid_in,
  input wire logic [7:0] rx_char_in,
  output logic rts_n_out,
  output logic tx_hold_out,
  output logic modem_int_out,
  output logic irq_out,
  output logic sw_match_out,
  output logic [1:0] sw_tx_mode_out,
  output logic [1:0] sw_rx_mode_out
);

  ////////////////////////////////////////////////////////////////////////////
  // state
  logic ack_q; // one-cycle bus answer
  logic [31:0] rdata_q; // registered read data
  logic [3:0] delta_q; // change flags cd, ri, dsr, cts
  logic [3:0] delta_d;
  msfc_pkg::msfc_pins_t prev_q; // last sampled pins
  logic primed_q; // prev_q holds a real sample
  logic [7:0] scratch_q; // scratch storage
  logic [7:0] efc_q; // enhanced feature control
  logic [2:0] fcfg_q; // trigger select and manual rts
  logic [1:0] irq_stat_q; // sticky events
  logic [1:0] irq_mask_q; // event enables
  logic [15:0] chars_q; // flow characters, first in low byte
  logic hold_q; // transmitter paused
  logic rts_flow_q; // auto rts holding the far end off
  logic at_trig_q; // level was at trigger last cycle
  logic half_q; // first of a dual pair seen
  logic match_q; // software character match pulse
  logic req; // bus request waiting for its answer
  logic wr_en; // write takes effect this edge
  logic rd_msr; // modem status read takes effect this edge
  logic [3:0] chg; // pin changes this cycle
  logic [6:0] upper_lvl; // rts rises at this level
  logic [6:0] lower_lvl; // rts falls below this level
  logic [6:0] prog_lvl; // programmed trigger
  logic trig_evt; // fifo reached the trigger
  logic [1:0] irq_set; // events this cycle

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  // trigger level for a two-bit select
  function automatic logic [6:0] trig_lvl(input logic [1:0] sel);
    case (sel)
      2'h0: trig_lvl = msfc_pkg::TRIG_LVL_0;
      2'h1: trig_lvl = msfc_pkg::TRIG_LVL_1;
      2'h2: trig_lvl = msfc_pkg::TRIG_LVL_2;
      default: trig_lvl = msfc_pkg::TRIG_LVL_3;
    endcase
  endfunction

  // two control bits into a mode; bit order puts the first char in bit 1
  function automatic msfc_pkg::msfc_sw_mode_t sw_mode(input logic [1:0] bits);
    case (bits)
      2'h0: sw_mode = msfc_pkg::MSFC_SW_NONE;
      2'h2: sw_mode = msfc_pkg::MSFC_SW_FIRST;
      2'h1: sw_mode = msfc_pkg::MSFC_SW_SECOND;
      default: sw_mode = msfc_pkg::MSFC_SW_BOTH;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // wishbone slave: answer one cycle after the request, for any address
  // a write commits at the edge where the master samples ack high, so a
  // write that is dropped before its answer never touches a register
  assign req = wb_cyc_in & wb_stb_in & ~ack_q;
  assign wr_en = wb_cyc_in & wb_stb_in & wb_we_in & ack_q;
  assign rd_msr = req & ~wb_we_in & (wb_adr_in == msfc_pkg::ADR_MODEM_LINE_STATUS);

  // ack drops the cycle after it was given
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req;
    end
  end

  // read mux, captured together with the ack; unmapped reads give zero
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_q <= 32'h00000000;
    end else if (req & ~wb_we_in) begin
      case (wb_adr_in)
        msfc_pkg::ADR_MODEM_LINE_STATUS: begin
          // pin levels inverted, change flags below
          rdata_q <= {24'h000000, ~pins_in, delta_q};
        end
        msfc_pkg::ADR_SCRATCH_STORAGE: rdata_q <= {24'h000000, scratch_q};
        msfc_pkg::ADR_ENHANCED_FEATURE: begin
          // enable reads back as written; live flow state sits in flow config
          rdata_q <= {24'h000000, efc_q};
        end
        msfc_pkg::ADR_IRQ_STATUS: rdata_q <= {30'h0, irq_stat_q};
        msfc_pkg::ADR_IRQ_MASK: rdata_q <= {30'h0, irq_mask_q};
        msfc_pkg::ADR_FLOW_CONFIG: rdata_q <= {23'h0, rts_flow_q, 5'h00, fcfg_q};
        msfc_pkg::ADR_FLOW_CHARS: rdata_q <= {16'h0000, chars_q};
        default: rdata_q <= 32'h00000000;
      endcase
    end
  end

  assign wb_ack_out = ack_q;
  assign wb_dat_out = rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // software-written registers, byte 0 lane unless noted
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      scratch_q <= msfc_pkg::SCRATCH_RESET;
      efc_q <= msfc_pkg::EFC_RESET;
      fcfg_q <= msfc_pkg::FCFG_RESET;
      irq_mask_q <= msfc_pkg::IRQ_MASK_RESET;
      chars_q <= msfc_pkg::CHARS_RESET;
    end else if (wr_en & wb_sel_in[0]) begin
      case (wb_adr_in)
        msfc_pkg::ADR_SCRATCH_STORAGE: scratch_q <= wb_dat_in[7:0];
        msfc_pkg::ADR_ENHANCED_FEATURE: efc_q <= wb_dat_in[7:0];
        msfc_pkg::ADR_FLOW_CONFIG: fcfg_q <= wb_dat_in[2:0];
        msfc_pkg::ADR_IRQ_MASK: irq_mask_q <= wb_dat_in[1:0];
        msfc_pkg::ADR_FLOW_CHARS: begin
          chars_q[7:0] <= wb_dat_in[7:0];
          if (wb_sel_in[1]) begin
            chars_q[15:8] <= wb_dat_in[15:8];
          end
        end
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // modem status change flags
  // ri flags only its trailing edge: the pin going from low back to high
  assign chg = primed_q ? {prev_q.cd_n ^ pins_in.cd_n, ~prev_q.ri_n & pins_in.ri_n,
                           prev_q.dsr_n ^ pins_in.dsr_n, prev_q.cts_n ^ pins_in.cts_n}
                        : 4'h0;

  // a change in the reading cycle survives the clear
  assign delta_d = (delta_q & {4{~rd_msr}}) | chg;

  // first sample after reset only primes, so reset does not fake a change
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      prev_q <= '1;
      primed_q <= 1'b0;
      delta_q <= 4'h0;
    end else begin
      prev_q <= pins_in;
      primed_q <= 1'b1;
      delta_q <= delta_d;
    end
  end

  assign modem_int_out = |delta_q;

  ////////////////////////////////////////////////////////////////////////////
  // automatic cts: pause only between characters
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      hold_q <= 1'b0;
    end else if (~efc_q[msfc_pkg::EFC_AUTO_CTS] | ~pins_in.cts_n) begin
      hold_q <= 1'b0;
    end else if (~tx_busy_in) begin
      hold_q <= 1'b1;
    end
  end

  assign tx_hold_out = hold_q;

  ////////////////////////////////////////////////////////////////////////////
  // automatic rts with hysteresis between neighbouring trigger levels
  assign prog_lvl = trig_lvl(fcfg_q[1:0]);
  assign upper_lvl = (fcfg_q[1:0] == 2'h3) ? msfc_pkg::TRIG_LVL_3 : trig_lvl(fcfg_q[1:0] + 2'h1);
  // the lowest select has no lower neighbour, so it falls below itself
  assign lower_lvl = (fcfg_q[1:0] == 2'h0) ? msfc_pkg::TRIG_LVL_0 : trig_lvl(fcfg_q[1:0] - 2'h1);

  // stays set between the two levels so rts does not chatter
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      rts_flow_q <= 1'b0;
    end else if (~efc_q[msfc_pkg::EFC_AUTO_RTS]) begin
      rts_flow_q <= 1'b0;
    end else if (rx_level_in >= upper_lvl) begin
      rts_flow_q <= 1'b1;
    end else if (rx_level_in < lower_lvl) begin
      rts_flow_q <= 1'b0;
    end
  end

  // pin is high after reset because manual rts resets to zero
  assign rts_n_out = rts_flow_q | ~fcfg_q[msfc_pkg::FCFG_MANUAL_RTS];

  // trigger event on the rising crossing only
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      at_trig_q <= 1'b0;
    end else begin
      at_trig_q <= rx_level_in >= prog_lvl;
    end
  end

  assign trig_evt = efc_q[msfc_pkg::EFC_AUTO_RTS] & (rx_level_in >= prog_lvl) & ~at_trig_q;

  ////////////////////////////////////////////////////////////////////////////
  // interrupt status: write one to clear, a new event wins over the clear
  assign irq_set = {trig_evt, |chg};

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      irq_stat_q <= 2'h0;
    end else if (wr_en & wb_sel_in[0] & (wb_adr_in == msfc_pkg::ADR_IRQ_STATUS)) begin
      irq_stat_q <= (irq_stat_q & ~wb_dat_in[1:0]) | irq_set;
    end else begin
      irq_stat_q <= irq_stat_q | irq_set;
    end
  end

  assign irq_out = |(irq_stat_q & irq_mask_q);

  ////////////////////////////////////////////////////////////////////////////
  // software flow selection and receive character matching
  assign sw_tx_mode_out = sw_mode(efc_q[3:2]);
  assign sw_rx_mode_out = sw_mode(efc_q[1:0]);

  // dual mode needs first char then second char, back to back
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      half_q <= 1'b0;
      match_q <= 1'b0;
    end else begin
      match_q <= 1'b0;
      if (rx_char_valid_in) begin
        half_q <= 1'b0;
        case (sw_mode(efc_q[1:0]))
          msfc_pkg::MSFC_SW_FIRST: match_q <= rx_char_in == chars_q[7:0];
          msfc_pkg::MSFC_SW_SECOND: match_q <= rx_char_in == chars_q[15:8];
          msfc_pkg::MSFC_SW_BOTH: begin
            if (half_q & (rx_char_in == chars_q[15:8])) begin
              match_q <= 1'b1;
            end else begin
              half_q <= rx_char_in == chars_q[7:0];
            end
          end
          default: ;
        endcase
      end
    end
  end

  assign sw_match_out = match_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);

  sequence s_cts_high_idle;
    efc_q[msfc_pkg::EFC_AUTO_CTS] && pins_in.cts_n && !tx_busy_in;
  endsequence

  chk_cts_flag_set: assert property (primed_q && $changed(pins_in.cts_n) |=> delta_q[0])
    else $error("cts change not flagged");
  chk_dsr_flag_set: assert property (primed_q && $changed(pins_in.dsr_n) |=> delta_q[1])
    else $error("dsr change not flagged");
  chk_modem_int_any: assert property (primed_q && ($changed(pins_in.cts_n)
      || $changed(pins_in.dsr_n) || $changed(pins_in.cd_n)) |=> modem_int_out)
    else $error("modem interrupt missing");
  chk_scratch_write: assert property (wr_en && wb_sel_in[0]
      && wb_adr_in == msfc_pkg::ADR_SCRATCH_STORAGE
      |=> scratch_q == $past(wb_dat_in[7:0]))
    else $error("scratch not stored");
  chk_cts_pause: assert property (s_cts_high_idle |=> tx_hold_out)
    else $error("transmit not paused");
  chk_char_finish: assert property ($rose(tx_hold_out) |-> !$past(tx_busy_in))
    else $error("paused mid character");
  chk_rts_raise: assert property (efc_q[6] && rx_level_in >= upper_lvl |=> rts_n_out)
    else $error("rts not raised");
  chk_rts_drop: assert property (efc_q[6] && rx_level_in < lower_lvl |=> !rts_flow_q)
    else $error("rts flow not released");
  chk_rts_manual: assert property (!efc_q[6] ##1 !efc_q[6] |-> rts_n_out == !fcfg_q[2])
    else $error("manual rts wrong");
  chk_read_clear: assert property (rd_msr && chg == 4'h0 |=> delta_q == 4'h0)
    else $error("flags not cleared on read");
  chk_trig_irq: assert property (trig_evt |=> irq_stat_q[1])
    else $error("trigger event lost");

endmodule
`default_nettype wire

/* testbench/msfc_modem_model.sv */
// modem model: drives the active-low handshake pins of one channel.
// assumes the bench names the wanted levels; pins move on clock edges only.
`timescale 1ns/100ps
`default_nettype none
module msfc_modem_model (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire msfc_pkg::msfc_pins_t want_in,
  output var msfc_pkg::msfc_pins_t pins_out
);
  ////////////////////////////////////////////////////////////////////////////
  // pin drivers: registered so the block sees synchronous levels
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      pins_out <= '1; // every line idle, deasserted
    end else begin
      pins_out <= want_in; // a change lands one edge after it is asked for
    end
  end
endmodule
`default_nettype wire

/* testbench/testbench.sv */
// self-checking bench for the modem status and flow control block.
// assumes a classic wishbone master here and a modem model on the pins.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic clk_sys_in = 1'b0;
  logic rst_in = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat_w = 32'h0, dat_r, rd, v, hits;
  logic ack, rts_n, tx_hold, modem_int, irq, sw_match, tx_busy = 1'b0, rx_valid = 1'b0;
  logic [6:0] rx_level = 7'h00;
  logic [7:0] rx_char = 8'h00;
  logic [1:0] tx_mode, rx_mode;
  logic [3:0] m;
  logic [3:0] sel = 4'hF; // byte lanes of the next request
  msfc_pkg::msfc_pins_t want = '1, pins;
  int n_errors = 0;
  int cmp_count = 0;
  logic [31:0] seed = 32'h1C34; // fixed seed keeps runs repeatable
  logic [6:0] lv [4] = '{7'h08, 7'h10, 7'h0C, 7'h07};
  logic ex [4] = '{1'b0, 1'b1, 1'b1, 1'b0}; // hysteresis: 12 keeps rts off
  // 25 MHz clock
  always #20 clk_sys_in = ~clk_sys_in;
  msfc_core dut_u (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .wb_cyc_in(cyc),
    .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel),
    .wb_dat_in(dat_w), .wb_dat_out(dat_r), .wb_ack_out(ack), .pins_in(pins),
    .rx_level_in(rx_level), .tx_busy_in(tx_busy), .rx_char_valid_in(rx_valid),
    .rx_char_in(rx_char), .rts_n_out(rts_n), .tx_hold_out(tx_hold),
    .modem_int_out(modem_int), .irq_out(irq), .sw_match_out(sw_match),
    .sw_tx_mode_out(tx_mode), .sw_rx_mode_out(rx_mode));
  msfc_modem_model model_u (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
    .want_in(want), .pins_out(pins));
  ////////////////////////////////////////////////////////////////////////////
  // expectation helpers
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // status byte: inverted pins above, change flags below
  function automatic logic [31:0] msr_exp(input msfc_pkg::msfc_pins_t p, input logic [3:0] f);
    return {24'h0, ~(4'(p)), f};
  endfunction
  // two select bits arrive swapped onto the mode outputs
  function automatic logic [1:0] sw_map(input logic [1:0] b);
    return {b[0], b[1]};
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  // verdict, compare and bus tasks
  task automatic tally_and_finish();
    if (n_errors == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one classic cycle; entered just after an edge, request held until ack
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat_w <= d;
    do begin
      @(posedge clk_sys_in);
      n++;
    end while (ack !== 1'b1 && n < 16);
    if (ack !== 1'b1) begin
      n_errors++; // a hung bus ends the run
      tally_and_finish();
    end
    q = dat_r;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk_sys_in); // idle gap before the next request
  endtask
  task automatic step(input int k);
    repeat (k) @(posedge clk_sys_in);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    step(4);
    rst_in <= 1'b0;
    step(3); // first edge only samples the pins
    chk("rts_n", 32'h1, 32'(rts_n));
    wb(1'b0, msfc_pkg::ADR_ENHANCED_FEATURE, 32'h0, rd);
    chk("efc", 32'h0, rd);
    // scratch keeps random bytes; unmapped place reads zero
    for (int i = 0; i < 4; i++) begin
      v = xs();
      wb(1'b1, msfc_pkg::ADR_SCRATCH_STORAGE, v, rd);
      wb(1'b0, msfc_pkg::ADR_SCRATCH_STORAGE, 32'h0, rd);
      chk("scratch", {24'h0, v[7:0]}, rd);
    end
    // a write without the low byte lane is ignored
    sel <= 4'hE;
    wb(1'b1, msfc_pkg::ADR_SCRATCH_STORAGE, ~v, rd);
    sel <= 4'hF;
    wb(1'b0, msfc_pkg::ADR_SCRATCH_STORAGE, 32'h0, rd);
    chk("scratch_lane", {24'h0, v[7:0]}, rd);
    wb(1'b0, 8'h40, 32'h0, rd);
    chk("unmapped", 32'h0, rd);
    chk("modem_int", 32'h0, 32'(modem_int));
    // random dsr/cts changes, flagged then cleared by a read
    for (int i = 0; i < 6; i++) begin
      m = {2'b00, 2'(xs())};
      if (m == 4'h0) m = 4'h1;
      want <= msfc_pkg::msfc_pins_t'(4'(want) ^ m);
      step(3);
      chk("modem_int", 32'h1, 32'(modem_int));
      wb(1'b0, msfc_pkg::ADR_MODEM_LINE_STATUS, 32'h0, rd);
      chk("msr", msr_exp(want, m), rd);
      wb(1'b0, msfc_pkg::ADR_MODEM_LINE_STATUS, 32'h0, rd);
      chk("msr_clr", msr_exp(want, 4'h0), rd);
      chk("modem_int", 32'h0, 32'(modem_int));
    end
    // interrupt raised, cleared, then masked
    wb(1'b1, msfc_pkg::ADR_IRQ_STATUS, 32'h3, rd);
    wb(1'b1, msfc_pkg::ADR_IRQ_MASK, 32'h1, rd);
    want.cts_n <= ~want.cts_n;
    step(3);
    chk("irq", 32'h1, 32'(irq));
    wb(1'b0, msfc_pkg::ADR_MODEM_LINE_STATUS, 32'h0, rd);
    wb(1'b1, msfc_pkg::ADR_IRQ_STATUS, 32'h1, rd);
    chk("irq_clr", 32'h0, 32'(irq));
    wb(1'b1, msfc_pkg::ADR_IRQ_MASK, 32'h0, rd);
    want.cts_n <= ~want.cts_n;
    step(3);
    chk("irq_masked", 32'h0, 32'(irq));
    wb(1'b0, msfc_pkg::ADR_IRQ_STATUS, 32'h0, rd);
    chk("irq_status", 32'h1, rd);
    // auto cts: busy character finishes before the pause
    wb(1'b1, msfc_pkg::ADR_ENHANCED_FEATURE, 32'h80, rd);
    tx_busy <= 1'b1;
    want.cts_n <= 1'b1;
    step(4);
    chk("tx_hold", 32'h0, 32'(tx_hold));
    tx_busy <= 1'b0;
    step(3);
    chk("tx_hold", 32'h1, 32'(tx_hold));
    want.cts_n <= 1'b0;
    step(3);
    chk("tx_hold", 32'h0, 32'(tx_hold));
    // auto rts against the lowest trigger, manual rts on
    wb(1'b0, msfc_pkg::ADR_MODEM_LINE_STATUS, 32'h0, rd);
    wb(1'b1, msfc_pkg::ADR_IRQ_STATUS, 32'h3, rd);
    wb(1'b1, msfc_pkg::ADR_FLOW_CONFIG, 32'h4, rd);
    wb(1'b1, msfc_pkg::ADR_ENHANCED_FEATURE, 32'h40, rd);
    for (int k = 0; k < 4; k++) begin
      rx_level <= lv[k];
      step(3);
      chk("rts_n", 32'(ex[k]), 32'(rts_n));
      if (k == 0) begin
        wb(1'b0, msfc_pkg::ADR_IRQ_STATUS, 32'h0, rd);
        chk("trig_irq", 32'h2, rd);
      end
      if (k == 1) begin
        wb(1'b0, msfc_pkg::ADR_FLOW_CONFIG, 32'h0, rd);
        chk("flow_state", 32'h104, rd);
      end
    end
    // flow off: rts follows the manual bit only
    rx_level <= 7'h3F;
    wb(1'b1, msfc_pkg::ADR_ENHANCED_FEATURE, 32'h0, rd);
    for (int k = 0; k < 2; k++) begin
      wb(1'b1, msfc_pkg::ADR_FLOW_CONFIG, 32'(k) << 2, rd);
      step(2);
      chk("rts_manual", 32'(k == 0), 32'(rts_n));
    end
    // every software flow selection, with read-back
    for (int s = 0; s < 16; s++) begin
      wb(1'b1, msfc_pkg::ADR_ENHANCED_FEATURE, 32'(s), rd);
      wb(1'b0, msfc_pkg::ADR_ENHANCED_FEATURE, 32'h0, rd);
      chk("efc", 32'(s), rd);
      chk("tx_mode", 32'(sw_map(2'(s >> 2))), 32'(tx_mode));
      chk("rx_mode", 32'(sw_map(2'(s))), 32'(rx_mode));
    end
    // dual characters match only in order
    wb(1'b1, msfc_pkg::ADR_FLOW_CHARS, 32'h1311, rd);
    wb(1'b1, msfc_pkg::ADR_ENHANCED_FEATURE, 32'h03, rd);
    for (int k = 0; k < 2; k++) begin
      hits = 32'h0;
      rx_valid <= 1'b1;
      rx_char <= (k == 0) ? 8'h11 : 8'h13;
      step(1);
      rx_char <= (k == 0) ? 8'h13 : 8'h11;
      step(1);
      rx_valid <= 1'b0;
      repeat (4) begin
        @(posedge clk_sys_in);
        hits = hits + 32'(sw_match === 1'b1);
      end
      chk("sw_match", 32'(k == 0), hits);
    end
    tally_and_finish();
  end
endmodule
`default_nettype wire
